// ### design/timer_pkg.sv
// Constants, register map and types shared by the timer and trigger counter
package timer_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Clock and time base

	localparam int CLK_SYS_MHZ         = 50;         // System clock rate in MHz
	localparam int LOW_TICK_PERIOD_NS  = 244140;     // Low-speed tick period in ns
	localparam int LOW_TICK_CYCLES     = (LOW_TICK_PERIOD_NS * CLK_SYS_MHZ) / 1000;
	localparam int PRESCALER_WIDTH     = 11;         // Widest high-speed tap is 2^11
	localparam int TAP_SLOW_BIT        = 10;         // Tap for clock / 2^11
	localparam int TAP_MID_BIT         = 6;          // Tap for clock / 2^7
	localparam int TAP_FAST_BIT        = 2;          // Tap for clock / 2^3
	localparam int LOW_TICK_WIDTH      = 16;         // Width of the low-speed divider

	////////////////////////////////////////////////////////////////////////////////
	// Pin noise filter, counted in system clock cycles

	localparam int NOISE_REJECT_CYCLES  = 4;         // Pulses this short are dropped
	localparam int NOISE_ACCEPT_CYCLES  = 12;        // Pulses this long always pass
	localparam int FILTER_STABLE_CYCLES = (NOISE_REJECT_CYCLES + NOISE_ACCEPT_CYCLES) / 2 - 2;
	localparam int FILTER_COUNT_WIDTH   = 4;         // Holds FILTER_STABLE_CYCLES

	////////////////////////////////////////////////////////////////////////////////
	// Register map, word addresses on the Avalon slave

	localparam logic [2:0] ADDR_CONTROL = 3'h0;      // counter_control_register
	localparam logic [2:0] ADDR_COMPARE = 3'h1;      // compare_register_a
	localparam logic [2:0] ADDR_CAPTURE = 3'h2;      // capture_register_b
	localparam logic [2:0] ADDR_STATUS  = 3'h3;      // Live counter and state

	// Control register fields
	localparam int CTRL_MODE_LSB   = 0;              // operating_mode_select [1:0]
	localparam int CTRL_CLK_LSB    = 2;              // source_clock_select [3:2]
	localparam int CTRL_START_LSB  = 4;              // start_edge_control [5:4]
	localparam int CTRL_OPTION_BIT = 6;              // Capture enable or trigger stop
	localparam int CTRL_TAP_BIT    = 8;              // prescaler_tap_select
	localparam int CTRL_WIDTH      = 9;              // Implemented control bits

	// Status register fields
	localparam int STAT_COUNTING_BIT = 16;           // Counter is advancing
	localparam int STAT_PENDING_BIT  = 17;           // Compare update waiting for a tick

	// Values after reset
	localparam logic [CTRL_WIDTH-1:0] CONTROL_RESET = 9'h000;
	localparam logic [15:0]           COMPARE_RESET = 16'hFFFF;
	localparam logic [15:0]           CAPTURE_RESET = 16'h0000;

	////////////////////////////////////////////////////////////////////////////////
	// Field encodings

	localparam logic [1:0] START_STOP    = 2'h0;     // Stop and clear
	localparam logic [1:0] START_COMMAND = 2'h1;     // Timer mode, start now
	localparam logic [1:0] START_RISING  = 2'h2;     // Trigger on rising edge
	localparam logic [1:0] START_FALLING = 2'h3;     // Trigger on falling edge
	localparam logic [1:0] MODE_TIMER    = 2'h0;     // Timer and trigger timer family
	localparam logic [1:0] CLK_SEL_SLOW  = 2'h0;     // Slowest internal source
	localparam logic [1:0] CLK_SEL_MID   = 2'h1;     // Middle internal source
	localparam logic [1:0] CLK_SEL_FAST  = 2'h2;     // Fastest internal source

	// Counter sequencing states
	typedef enum logic [1:0] {
		ST_STOPPED,
		ST_TIMER,
		ST_WAIT_TRIGGER,
		ST_COUNTING
	} count_state_t;

endpackage

// ### design/pin_noise_filter.sv
// Synchroniser and digital noise filter for the trigger input pin
`timescale 1ns/1ps
`default_nettype none

module pin_noise_filter
	import timer_pkg::*;
(
	input  wire logic clk_sys,       // System clock
	input  wire logic rst_n,         // Asynchronous reset, active low
	input  wire logic pin_raw,       // Asynchronous pin level
	input  wire logic bypass,        // Skip the stability window
	output var  logic pin_filtered   // Clean pin level
);
	import timer_pkg::*;

	logic                          sync_a;        // First synchroniser stage
	logic                          sync_b;        // Second stage
	logic                          sync_c;        // Third stage
	logic [FILTER_COUNT_WIDTH-1:0] stable_count;  // Agreeing cycles at the new level
	wire                           agree;         // Second and third stages agree
	wire                           differs;       // Settled level differs from output
	wire                           window_full;   // New level held long enough

	assign agree       = (sync_b == sync_c);
	assign differs     = agree && (sync_c != pin_filtered);
	assign window_full = (stable_count == FILTER_STABLE_CYCLES[FILTER_COUNT_WIDTH-1:0] - 4'h1);

	////////////////////////////////////////////////////////////////////////////////
	// Three-stage synchroniser; only sync_b reads sync_a
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
			sync_c <= 1'b0;
		end else begin
			sync_a <= pin_raw;
			sync_b <= sync_a;
			sync_c <= sync_b;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Stability window: short pulses reach the output only while bypass is set
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			stable_count <= '0;
			pin_filtered <= 1'b0;
		end else if (!differs) begin
			// Back at the old level: the glitch is dropped
			stable_count <= '0;
		end else if (bypass || window_full) begin
			// Low-speed modes take the settled level at once
			pin_filtered <= sync_c;
			stable_count <= '0;
		end else begin
			stable_count <= stable_count + 4'h1;
		end
	end

endmodule

`default_nettype wire

// ### design/timer_and_trigger_counter.sv
// Sixteen-bit timer and external trigger counter with Avalon-MM registers
//
// Overview of operation
// - Four mode encodings exist; timer and trigger implemented
// - Timer mode counts each selected source tick
// - Timer match raises request, clears, keeps counting
// - Capture enabled copies count every source tick
// - Source select picks prescaler tap or low clock
// - Trigger edge on pin starts the count
// - Trigger mode match clears, halts, raises request
// - Stop option: opposite edge clears, halts, silently
// - Halted counter restarts from zero on trigger
// - Without stop option opposite edges do nothing
// - Without stop option retrigger while counting ignored
// - Filter drops short pin pulses, source holds long
// - Low-speed modes bypass the filter
// - Compare updates on first tick after upper byte
// - Stop power mode forces start field to stop
`timescale 1ns/1ps
`default_nettype none

module timer_and_trigger_counter
	import timer_pkg::*;
#(
	parameter int LOW_TICK_DIV = timer_pkg::LOW_TICK_CYCLES  // Cycles per low-speed tick
)
(
	input  wire logic        clk_sys,             // System clock, 50 MHz
	input  wire logic        rst_n,               // Asynchronous reset, active low
	input  wire logic [2:0]  address,             // Avalon word address
	input  wire logic        read,                // Avalon read request
	input  wire logic        write,               // Avalon write request
	input  wire logic [31:0] writedata,           // Avalon write data
	input  wire logic [3:0]  byteenable,          // Avalon byte enables
	output var  logic [31:0] readdata,            // Avalon read data
	output var  logic        waitrequest,         // Avalon wait request
	input  wire logic        trigger_input_pin,   // External trigger pin, asynchronous
	input  wire logic        low_speed_run_mode,  // Chip runs from the low clock
	input  wire logic        low_speed_sleep_mode,// Chip sleeps on the low clock
	input  wire logic        stop_mode_entry,     // Chip enters stop power mode
	output var  logic        counter_match_irq    // Match request pulse
);
	import timer_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Declarations

	// Register state
	logic [CTRL_WIDTH-1:0]      control;          // counter_control_register
	logic [15:0]                compare_active;   // Compare value in use
	logic [15:0]                compare_pending;  // Value waiting for a tick
	logic                       pending_valid;    // A committed update is waiting
	logic [7:0]                 compare_low;      // Lower byte shift stage
	logic [15:0]                capture_value;    // capture_register_b
	logic [15:0]                count;            // The up-counter
	count_state_t               state;            // Counter sequencing state

	// Time base
	logic [PRESCALER_WIDTH-1:0] prescaler;        // Free-running high-speed divider
	logic [LOW_TICK_WIDTH-1:0]  low_div;          // Low-speed tick divider
	logic                       low_tick;         // One-cycle low-speed tick

	// Pin edge detection
	logic                       pin_clean;        // Filtered pin level
	logic                       pin_prev;         // Filtered level one cycle earlier

	// Bus handshake
	logic                       ack;              // Bus access being answered

	// Decoded fields
	wire [1:0]                  mode_sel;         // operating_mode_select
	wire [1:0]                  clk_sel;          // source_clock_select
	wire [1:0]                  start_sel;        // start_edge_control
	wire                        option_bit;       // Capture enable or stop select
	wire                        tap_sel;          // prescaler_tap_select
	wire                        low_speed;        // Any low-clock power mode
	wire                        auto_capture_enable;
	wire                        trigger_stop_select;

	// Tick and event terms
	wire                        tick_slow;        // High clock / 2^11
	wire                        tick_mid;         // High clock / 2^7
	wire                        tick_fast;        // High clock / 2^3
	wire                        source_tick;      // Selected source tick
	wire                        rise_edge;        // Filtered rising edge
	wire                        fall_edge;        // Filtered falling edge
	wire                        trigger_edge;     // Edge that starts the count
	wire                        opposite_edge;    // Edge that may stop the count
	wire [15:0]                 count_inc;        // Counter plus one
	wire                        match;            // Next count hits compare
	wire                        run_enabled;      // Start field and mode allow running
	wire                        counting;         // Counter advances on ticks

	// Bus terms
	wire                        bus_req;          // New request this cycle
	wire                        write_take;       // Write lands at this edge
	wire                        wr_control;       // Write to control register
	wire                        wr_compare;       // Write to compare register
	wire                        commit_upper;     // Upper compare byte written
	wire [15:0]                 commit_value;     // Value committed by upper byte
	wire [31:0]                 read_mux;         // Read data selected by address
	wire [CTRL_WIDTH-1:0]       control_written;  // Control after byte enables
	wire [CTRL_WIDTH-1:0]       next_control;     // Control after stop mode forcing

	////////////////////////////////////////////////////////////////////////////////
	// Functions

	// Merge write data into a register by byte enables
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_value,
	                                            input logic [31:0] new_value,
	                                            input logic [3:0]  lanes);
		logic [31:0] result;
		result = old_value;
		for (int i = 0; i < 4; i++) begin
			if (lanes[i]) begin
				result[i*8 +: 8] = new_value[i*8 +: 8];
			end
		end
		return result;
	endfunction

	// Tick of one prescaler tap: all bits up to the tap are ones
	function automatic logic tap_tick(input logic [PRESCALER_WIDTH-1:0] value,
	                                  input int                         bit_pos);
		logic hit;
		hit = 1'b1;
		for (int i = 0; i < PRESCALER_WIDTH; i++) begin
			if (i <= bit_pos) begin
				hit = hit & value[i];
			end
		end
		return hit;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Field decoding

	assign mode_sel   = control[CTRL_MODE_LSB +: 2];
	assign clk_sel    = control[CTRL_CLK_LSB +: 2];
	assign start_sel  = control[CTRL_START_LSB +: 2];
	assign option_bit = control[CTRL_OPTION_BIT];
	assign tap_sel    = control[CTRL_TAP_BIT];
	assign low_speed  = low_speed_run_mode | low_speed_sleep_mode;

	// The shared option bit means capture in timer mode, stop in trigger mode
	assign auto_capture_enable = option_bit && (start_sel == START_COMMAND);
	assign trigger_stop_select = option_bit && (start_sel != START_COMMAND);

	// Only the timer family runs; other modes stay halted
	assign run_enabled = (mode_sel == MODE_TIMER) && (start_sel != START_STOP);
	assign counting    = (state == ST_TIMER) || (state == ST_COUNTING);

	////////////////////////////////////////////////////////////////////////////////
	// Source clock selection

	assign tick_slow = tap_tick(prescaler, TAP_SLOW_BIT);
	assign tick_mid  = tap_tick(prescaler, TAP_MID_BIT);
	assign tick_fast = tap_tick(prescaler, TAP_FAST_BIT);

	// Low clock serves slowest select on the alternate tap or in low-speed modes
	assign source_tick =
		(clk_sel == CLK_SEL_SLOW) ? ((low_speed || tap_sel) ? low_tick : tick_slow) :
		(clk_sel == CLK_SEL_MID)  ? (!low_speed && tick_mid)  :
		(clk_sel == CLK_SEL_FAST) ? (!low_speed && tick_fast) :
		1'b0;

	// Free-running high-speed prescaler
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			prescaler <= '0;
		end else begin
			prescaler <= prescaler + 11'h001;
		end
	end

	// Low-speed tick divider, one pulse each LOW_TICK_DIV cycles
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			low_div  <= '0;
			low_tick <= 1'b0;
		end else if (low_div == LOW_TICK_WIDTH'(LOW_TICK_DIV - 1)) begin
			low_div  <= '0;
			low_tick <= 1'b1;
		end else begin
			low_div  <= low_div + 16'h0001;
			low_tick <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Trigger pin conditioning

	// Filter is bypassed while the chip runs or sleeps on the low clock
	pin_noise_filter pin_noise_filter_inst (
		.clk_sys      (clk_sys),
		.rst_n        (rst_n),
		.pin_raw      (trigger_input_pin),
		.bypass       (low_speed),
		.pin_filtered (pin_clean)
	);

	// Previous filtered level for edge detection
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pin_prev <= 1'b0;
		end else begin
			pin_prev <= pin_clean;
		end
	end

	assign rise_edge     = pin_clean && !pin_prev;
	assign fall_edge     = !pin_clean && pin_prev;
	assign trigger_edge  = (start_sel == START_RISING) ? rise_edge : fall_edge;
	assign opposite_edge = (start_sel == START_RISING) ? fall_edge : rise_edge;

	////////////////////////////////////////////////////////////////////////////////
	// Counter sequencing

	assign count_inc = count + 16'h0001;
	assign match     = (count_inc == compare_active);

	// State, count and match request
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state             <= ST_STOPPED;
			count             <= '0;
			counter_match_irq <= 1'b0;
		end else begin
			counter_match_irq <= 1'b0;
			case (state)
				ST_STOPPED: begin
					// Held at zero until a start value is written
					count <= '0;
					if (run_enabled && start_sel == START_COMMAND) begin
						state <= ST_TIMER;
					end else if (run_enabled) begin
						state <= ST_WAIT_TRIGGER;
					end
				end
				ST_TIMER: begin
					if (!run_enabled) begin
						state <= ST_STOPPED;
						count <= '0;
					end else if (source_tick && match) begin
						count             <= '0;
						counter_match_irq <= 1'b1;
					end else if (source_tick) begin
						count <= count_inc;
					end
				end
				ST_WAIT_TRIGGER: begin
					// Halted at zero; opposite edges are meaningless here
					count <= '0;
					if (!run_enabled) begin
						state <= ST_STOPPED;
					end else if (trigger_edge) begin
						state <= ST_COUNTING;
					end
				end
				ST_COUNTING: begin
					// Retrigger edges are ignored while counting
					if (!run_enabled) begin
						state <= ST_STOPPED;
						count <= '0;
					end else if (source_tick && match) begin
						// Match wins over an opposite edge in the same cycle
						state             <= ST_WAIT_TRIGGER;
						count             <= '0;
						counter_match_irq <= 1'b1;
					end else if (trigger_stop_select && opposite_edge) begin
						state <= ST_WAIT_TRIGGER;
						count <= '0;
					end else if (source_tick) begin
						count <= count_inc;
					end
				end
				default: begin
					state <= ST_STOPPED;
					count <= '0;
				end
			endcase
		end
	end

	// Auto-capture copies the running count on every source tick
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			capture_value <= CAPTURE_RESET;
		end else if (auto_capture_enable && state == ST_TIMER && source_tick) begin
			capture_value <= count;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Avalon-MM slave

	assign bus_req    = (read || write) && !ack;
	assign write_take = write && ack;
	assign wr_control = write_take && (address == ADDR_CONTROL);
	assign wr_compare = write_take && (address == ADDR_COMPARE);

	// Upper byte commits the pair; lower byte alone only loads the stage
	assign commit_upper = wr_compare && byteenable[1];
	assign commit_value = {writedata[15:8], byteenable[0] ? writedata[7:0] : compare_low};

	// Control after byte enables, then stop power mode overrides the start field
	assign control_written = CTRL_WIDTH'(merge_bytes(32'(control), writedata, byteenable));
	assign next_control    = stop_mode_entry ?
		{control_written[CTRL_WIDTH-1:CTRL_START_LSB+2], START_STOP,
		 control_written[CTRL_START_LSB-1:0]} : control_written;

	assign read_mux =
		(address == ADDR_CONTROL) ? 32'(control) :
		(address == ADDR_COMPARE) ? {16'h0000, compare_active} :
		(address == ADDR_CAPTURE) ? {16'h0000, capture_value} :
		(address == ADDR_STATUS)  ? {14'h0000, pending_valid, counting, count} :
		32'h0000_0000;

	// One wait cycle per access; read data stand when waitrequest drops
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ack         <= 1'b0;
			waitrequest <= 1'b1;
			readdata    <= '0;
		end else if (bus_req) begin
			ack         <= 1'b1;
			waitrequest <= 1'b0;
			readdata    <= read ? read_mux : 32'h0000_0000;
		end else begin
			ack         <= 1'b0;
			waitrequest <= 1'b1;
		end
	end

	// Control register; stop power mode applies even without a write
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			control <= CONTROL_RESET;
		end else if (wr_control || stop_mode_entry) begin
			control <= wr_control ? next_control :
				{control[CTRL_WIDTH-1:CTRL_START_LSB+2], START_STOP,
				 control[CTRL_START_LSB-1:0]};
		end
	end

	// Compare staging; an upper-byte write beats a tick that would consume it
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			compare_low     <= COMPARE_RESET[7:0];
			compare_pending <= COMPARE_RESET;
			pending_valid   <= 1'b0;
			compare_active  <= COMPARE_RESET;
		end else begin
			if (wr_compare && byteenable[0]) begin
				compare_low <= writedata[7:0];
			end
			if (source_tick && pending_valid) begin
				compare_active <= compare_pending;
			end
			if (commit_upper) begin
				compare_pending <= commit_value;
				pending_valid   <= 1'b1;
			end else if (source_tick) begin
				pending_valid <= 1'b0;
			end
		end
	end

endmodule

`default_nettype wire

// ### testbench/timer_sva.sv
// Port-level checker for the timer and trigger counter
`timescale 1ns/1ps
`default_nettype none
module timer_sva (
	input wire logic        clk_sys,           // System clock
	input wire logic        rst_n,             // Reset, active low
	input wire logic [2:0]  address,           // Word address
	input wire logic        read,              // Read request
	input wire logic        write,             // Write request
	input wire logic [31:0] readdata,          // Read data
	input wire logic        waitrequest,       // Wait request
	input wire logic        counter_match_irq  // Match pulse
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// Request accepted by an idle slave
	sequence s_taken;
		(read || write) && waitrequest;
	endsequence
	a_wait_answer: assert property (s_taken |=> !waitrequest) else $error("no answer");
	a_wait_once: assert property (!waitrequest |=> waitrequest) else $error("long answer");
	a_wait_idle: assert property (!read && !write && waitrequest |=> waitrequest)
		else $error("answer without request");
	a_unmapped_zero: assert property (read && address[2] && !waitrequest |-> readdata == 32'h0)
		else $error("unmapped read not zero");
	a_write_zero: assert property (write && !waitrequest |-> readdata == 32'h0)
		else $error("write left read data");
	a_data_stable: assert property (waitrequest && !read && !write |=> $stable(readdata))
		else $error("read data moved");
	a_irq_pulse: assert property (counter_match_irq |=> !counter_match_irq)
		else $error("match pulse too long");
	a_irq_spacing: assert property (counter_match_irq |=> !counter_match_irq [*7])
		else $error("match pulses too close");
	a_reset_quiet: assert property ($rose(rst_n) |-> waitrequest && !counter_match_irq)
		else $error("outputs active after reset");
endmodule
`default_nettype wire

// ### testbench/pulse_source.sv
// External pulse source driving the trigger pin
`timescale 1ns/1ps
`default_nettype none
module pulse_source (
	input wire logic clk_sys,  // System clock
	output var logic pin       // Trigger pin level
);
	initial pin = 1'b0;
	// Set a level just after an edge and keep it for n cycles
	task hold(input logic lvl, input int n);
		@(posedge clk_sys);
		pin <= lvl;
		repeat (n) @(posedge clk_sys);
	endtask
endmodule
`default_nettype wire

// ### testbench/timer_and_trigger_counter_tb.sv
// Self-checking bench for the timer and trigger counter
`timescale 1ns/1ps
`default_nettype none
module timer_and_trigger_counter_tb;
	import timer_pkg::*;
	logic clk_sys = 1'b0, rst_n = 1'b0, read = 1'b0, write = 1'b0, stop_mode_entry = 1'b0;
	logic [2:0]  address = 3'h0;   // Bus address
	logic [31:0] writedata = 32'h0; // Bus write data
	logic [3:0]  byteenable = 4'hF; // Bus lanes
	logic [31:0] readdata, q;       // Read data, last read
	logic        waitrequest, counter_match_irq, pin;
	logic        low_run = 1'b0, low_sleep = 1'b0; // Low-clock power modes
	int          fails = 0, tests_run = 0, n;
	always #10 clk_sys = ~clk_sys;
	pulse_source pulse_source_inst (.clk_sys(clk_sys), .pin(pin));
	timer_and_trigger_counter #(.LOW_TICK_DIV(16)) timer_and_trigger_counter_inst (
		.clk_sys(clk_sys), .rst_n(rst_n), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable), .readdata(readdata),
		.waitrequest(waitrequest), .trigger_input_pin(pin), .low_speed_run_mode(low_run),
		.low_speed_sleep_mode(low_sleep), .stop_mode_entry(stop_mode_entry),
		.counter_match_irq(counter_match_irq));
	////////////////////////////////////////////////////////////////////////////////
	// Compare, bus access, waiting and the verdict
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task bus(input logic w, input logic [2:0] a, input logic [31:0] d, input logic [3:0] be);
		@(posedge clk_sys);
		address <= a; writedata <= d; byteenable <= be; read <= !w; write <= w;
		@(posedge clk_sys);
		while (waitrequest !== 1'b0) @(posedge clk_sys);
		q = readdata;
		read <= 1'b0; write <= 1'b0;
	endtask
	// Stop first so settings only change while stopped, then start
	task run(input logic [31:0] v);
		bus(1'b1, ADDR_CONTROL, v & 32'hFFFFFFCF, 4'hF);
		bus(1'b1, ADDR_CONTROL, v, 4'hF);
	endtask
	// Count edges until a match pulse or the limit
	task wait_irq(input int lim);
		n = 0;
		while (counter_match_irq !== 1'b1 && n < lim) begin @(posedge clk_sys); n++; end
		@(posedge clk_sys);
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task t_reset;
		bus(1'b0, ADDR_CONTROL, 0, 4'hF); chk(q, 32'h0);
		bus(1'b0, ADDR_COMPARE, 0, 4'hF); chk(q, 32'h0000FFFF);
		bus(1'b1, 3'h5, 32'hFFFF, 4'hF); bus(1'b0, 3'h5, 0, 4'hF); chk(q, 32'h0);
	endtask
	// Lower byte alone keeps the old compare; full write takes effect
	task t_timer;
		bus(1'b1, ADDR_COMPARE, 32'h5, 4'h3);
		bus(1'b1, ADDR_COMPARE, 32'h3, 4'h1);
		run(32'h18); wait_irq(3000); wait_irq(3000); chk(n + 1, 40);
		bus(1'b1, ADDR_COMPARE, 32'h3, 4'h3); wait_irq(3000); wait_irq(3000);
		chk(n + 1, 24);
		stop_mode_entry <= 1'b1; @(posedge clk_sys); stop_mode_entry <= 1'b0;
		bus(1'b0, ADDR_CONTROL, 0, 4'hF); chk(q & 32'h30, 32'h0);
		wait_irq(100); chk(n, 100);
	endtask
	// Trigger start: glitch rejected, opposite edge and retrigger ignored, match halts
	task t_trigger;
		bus(1'b1, ADDR_COMPARE, 32'h5, 4'h3); run(32'h28);
		pulse_source_inst.hold(1'b1, 4); pulse_source_inst.hold(1'b0, 30);
		wait_irq(60); chk(n, 60);
		pulse_source_inst.hold(1'b1, 12); pulse_source_inst.hold(1'b0, 12);
		pulse_source_inst.hold(1'b1, 12);
		wait_irq(60); chk(n > 4 && n < 20, 1);
		pulse_source_inst.hold(1'b0, 12); wait_irq(200); chk(n, 200);
	endtask
	// Trigger stop: opposite edge halts silently, next edge restarts
	task t_trig_stop;
		run(32'h68);
		pulse_source_inst.hold(1'b1, 20); pulse_source_inst.hold(1'b0, 20);
		wait_irq(200); chk(n, 200);
		bus(1'b0, ADDR_STATUS, 0, 4'hF); chk(q & 32'h1FFFF, 32'h0);
		pulse_source_inst.hold(1'b1, 12); wait_irq(60); chk(n > 20 && n < 45, 1);
	endtask
	// Capture holds the count of the match tick; read while running, ticks after enable
	task t_capture;
		run(32'h58); wait_irq(3000);
		bus(1'b0, ADDR_CAPTURE, 0, 4'hF); chk(q, 32'h4);
	endtask
	// Low-clock modes: short pulse passes the bypassed filter, slowest select uses low tick
	task t_low_speed;
		low_run <= 1'b1; pulse_source_inst.hold(1'b0, 12); run(32'h20);
		pulse_source_inst.hold(1'b1, 4); pulse_source_inst.hold(1'b0, 30);
		wait_irq(150); chk(n > 30 && n < 60, 1);
		low_run <= 1'b0; low_sleep <= 1'b1; run(32'h10);
		wait_irq(300); wait_irq(300); chk(n + 1, 80);
		low_sleep <= 1'b0;
	endtask
	initial begin
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_reset; t_timer; t_trigger; t_trig_stop; t_capture; t_low_speed;
		give_verdict;
	end
	// Watchdog against a hang
	initial begin
		#1000000;
		fails++;
		give_verdict;
	end
endmodule
bind timer_and_trigger_counter timer_sva timer_sva_inst (.clk_sys(clk_sys), .rst_n(rst_n),
	.address(address), .read(read), .write(write), .readdata(readdata),
	.waitrequest(waitrequest), .counter_match_irq(counter_match_irq));
`default_nettype wire
